// ### hdl/rtc_time_regs.sv
/*
 * rtc_time_regs: time and calendar value registers with BCD counting,
 * a half-second status flag and a read synchronisation flag.
 * Assumes a one-cycle strobe register port on the same clock.
 */
`timescale 1ns/10ps
module rtc_time_regs
    import rtc_regs_pkg::*;
#(
    parameter int HALF_CYCLES = rtc_regs_pkg::HALF_SEC_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [rtc_regs_pkg::ADDR_W-1:0] i_addr,
    input wire logic [rtc_regs_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [rtc_regs_pkg::DATA_W-1:0] o_rdata,
    output logic o_half_second_flag,
    output logic o_sync_flag
);
    import rtc_regs_pkg::*;

    // ************************************************************
    // decode
    // ************************************************************
    logic wr_sec, wr_hm, wr_dw, wr_ym;
    assign wr_sec = i_wr && (i_addr == ADDR_SECONDS_VALUE);
    assign wr_hm = i_wr && (i_addr == ADDR_HOURS_MINUTES_VALUE);
    assign wr_dw = i_wr && (i_addr == ADDR_DAY_WEEKDAY_VALUE);
    assign wr_ym = i_wr && (i_addr == ADDR_YEAR_MONTH_VALUE);

    // ************************************************************
    // half-second timebase
    // ************************************************************
    logic half, sec_tick, near_tick;

    half_sec_timer #(
        .HALF_CYCLES(HALF_CYCLES),
        .LEAD(SYNC_LEAD_CYCLES)
    ) u_timer (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_clr(wr_sec),
        .o_half(half),
        .o_sec_tick(sec_tick),
        .o_near_tick(near_tick)
    );

    // ************************************************************
    // digit chain: index order low to high
    // ************************************************************
    // 0 sec1 1 sec10 2 min1 3 min10 4 hr1 5 hr10 6 day1 7 day10
    // 8 mth1 9 mth10 10 yr1 11 yr10 12 weekday_field
    localparam int ND = 13;
    logic [3:0] dv [ND];
    logic [3:0] lv [ND];
    logic [3:0] lim [ND];
    logic [3:0] wrapv [ND];
    logic [3:0] rstv [ND];
    logic ld [ND];
    logic inc [ND];
    logic cy [ND];

    // field loads keep only implemented bits
    assign lv[0] = i_wdata[SEC_ONE_LSB +: DIGIT_W];
    assign lv[1] = {1'b0, i_wdata[SEC_TEN_LSB +: SEC_TEN_W]};
    assign lv[2] = i_wdata[MIN_ONE_LSB +: DIGIT_W];
    assign lv[3] = {1'b0, i_wdata[MIN_TEN_LSB +: MIN_TEN_W]};
    assign lv[4] = i_wdata[HR_ONE_LSB +: DIGIT_W];
    assign lv[5] = {2'b00, i_wdata[HR_TEN_LSB +: HR_TEN_W]};
    assign lv[6] = i_wdata[DAY_ONE_LSB +: DIGIT_W];
    assign lv[7] = {2'b00, i_wdata[DAY_TEN_LSB +: DAY_TEN_W]};
    assign lv[8] = i_wdata[MTH_ONE_LSB +: DIGIT_W];
    assign lv[9] = {3'b000, i_wdata[MTH_TEN_LSB]};
    assign lv[10] = i_wdata[YR_ONE_LSB +: DIGIT_W];
    assign lv[11] = i_wdata[YR_TEN_LSB +: DIGIT_W];
    assign lv[12] = {1'b0, i_wdata[WEEKDAY_FIELD_LSB +: WEEKDAY_FIELD_W]};

    assign ld[0] = wr_sec;
    assign ld[1] = wr_sec;
    assign ld[2] = wr_hm;
    assign ld[3] = wr_hm;
    assign ld[4] = wr_hm;
    assign ld[5] = wr_hm;
    assign ld[6] = wr_dw;
    assign ld[7] = wr_dw;
    assign ld[12] = wr_dw;
    assign ld[8] = wr_ym;
    assign ld[9] = wr_ym;
    assign ld[10] = wr_ym;
    assign ld[11] = wr_ym;

    assign rstv[0] = RST_SECONDS[SEC_ONE_LSB +: DIGIT_W];
    assign rstv[6] = RST_DAY_WEEKDAY[DAY_ONE_LSB +: DIGIT_W];
    assign rstv[8] = RST_YEAR_MONTH[MTH_ONE_LSB +: DIGIT_W];

    // hour, day and month units limits depend on the tens digit
    logic hr_end, day_end, mth_end;
    assign hr_end = (dv[5] == LIM_TWO) && (dv[4] == HR_LAST_ONE);
    assign day_end = (dv[7] == LIM_THREE) && (dv[6] == DAY_LAST_ONE);
    assign mth_end = (dv[9] == LIM_ONE) && (dv[8] == MTH_LAST_ONE);

    // day and month count from one, so their wraps land on 1 or 0
    always_comb begin
        lim[0] = LIM_NINE;
        lim[1] = LIM_FIVE;
        lim[2] = LIM_NINE;
        lim[3] = LIM_FIVE;
        lim[4] = hr_end ? HR_LAST_ONE : LIM_NINE;
        lim[5] = LIM_TWO;
        lim[6] = day_end ? DAY_LAST_ONE : LIM_NINE;
        lim[7] = LIM_THREE;
        lim[8] = mth_end ? MTH_LAST_ONE : LIM_NINE;
        lim[9] = LIM_ONE;
        lim[10] = LIM_NINE;
        lim[11] = LIM_NINE;
        lim[12] = LIM_SIX;
        for (int k = 0; k < ND; k++) begin
            wrapv[k] = 4'h0;
        end
        wrapv[6] = day_end ? LIM_ONE : 4'h0;
        wrapv[8] = mth_end ? LIM_ONE : 4'h0;
    end

    // carry chain; a digit's own write blocks its increment
    always_comb begin
        inc[0] = sec_tick;
        inc[1] = cy[0];
        inc[2] = cy[1];
        inc[3] = cy[2];
        inc[4] = cy[3];
        inc[5] = cy[4] && hr_end;
        inc[6] = cy[5];
        inc[12] = cy[5];
        // day tens moves on a units wrap; month units moves on a day tens wrap or at day end
        inc[7] = cy[6];
        inc[8] = cy[7] || (cy[6] && day_end);
        inc[9] = cy[8] && mth_end;
        inc[10] = cy[9];
        inc[11] = cy[10];
    end

    // ************************************************************
    // digit instances
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < ND; g++) begin : g_dig
            logic [3:0] q;
            bcd_digit #(
                .W(DIGIT_W)
            ) u_dig (
                .i_clk(i_clk),
                .i_rst(i_rst),
                .i_ce(i_ce),
                .i_rst_val(4'h0),
                .i_load(ld[g]),
                .i_load_val(lv[g]),
                .i_inc(inc[g] && !ld[g]),
                .i_limit(lim[g]),
                .i_wrap_val(wrapv[g]),
                .o_val(q),
                .o_carry(cy[g])
            );
            // day and month units hold one after reset
            if (g == 6 || g == 8) begin : g_one
                logic seen_ff;
                always_ff @(posedge i_clk or posedge i_rst) begin
                    if (i_rst) begin
                        seen_ff <= 1'b0;
                    end else if (i_ce && (ld[g] || inc[g])) begin
                        seen_ff <= 1'b1;
                    end
                end
                assign dv[g] = seen_ff ? q : (q | rstv[g]);
            end else begin : g_pl
                assign dv[g] = q;
            end
        end
    endgenerate

    // ************************************************************
    // read path
    // ************************************************************
    logic [DATA_W-1:0] sec_word, hm_word, dw_word, ym_word, st_word;
    logic [DATA_W-1:0] nxt_rdata;

    // unused positions are constant zero
    assign sec_word = {1'b0, dv[1][2:0], dv[0], 8'h00} & MASK_SECONDS;
    assign hm_word = {2'b00, dv[5][1:0], dv[4], 1'b0, dv[3][2:0], dv[2]}
        & MASK_HOURS_MINUTES;
    assign dw_word = {2'b00, dv[7][1:0], dv[6], 5'b00000, dv[12][2:0]}
        & MASK_DAY_WEEKDAY;
    assign ym_word = {dv[11], dv[10], 3'b000, dv[9][0], dv[8]}
        & MASK_YEAR_MONTH;

    always_comb begin
        st_word = 16'h0000;
        st_word[STAT_HALF_SEC_BIT] = half;
        st_word[STAT_SYNC_BIT] = near_tick;
    end

    always_comb begin
        case (i_addr)
            ADDR_SECONDS_VALUE: nxt_rdata = sec_word;
            ADDR_HOURS_MINUTES_VALUE: nxt_rdata = hm_word;
            ADDR_DAY_WEEKDAY_VALUE: nxt_rdata = dw_word;
            ADDR_YEAR_MONTH_VALUE: nxt_rdata = ym_word;
            ADDR_CLOCK_STATUS_LOW: nxt_rdata = st_word;
            default: nxt_rdata = 16'h0000;
        endcase
    end

    // read data stand for exactly the cycle after the strobe
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 16'h0000;
        end else if (i_ce) begin
            o_rdata <= i_rd ? nxt_rdata : 16'h0000;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_half_second_flag <= 1'b0;
            o_sync_flag <= 1'b0;
        end else if (i_ce) begin
            o_half_second_flag <= wr_sec ? 1'b0 : half;
            o_sync_flag <= near_tick;
        end
    end

endmodule

// ### hdl/rtc_regs_pkg.sv
/*
 * rtc_regs_pkg: register indices, bit field positions, reset values and
 * timing constants for the time and calendar register block.
 * Assumes a 16-bit plain register port and a 200 MHz block clock.
 */
package rtc_regs_pkg;

    // ************************************************************
    // bus geometry
    // ************************************************************
    localparam int ADDR_W = 3;
    localparam int DATA_W = 16;

    // ************************************************************
    // register indices
    // ************************************************************
    localparam logic [ADDR_W-1:0] ADDR_SECONDS_VALUE = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_HOURS_MINUTES_VALUE = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_DAY_WEEKDAY_VALUE = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_YEAR_MONTH_VALUE = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_CLOCK_STATUS_LOW = 3'h4;

    // ************************************************************
    // field positions (lsb) and widths
    // ************************************************************
    localparam int SEC_TEN_LSB = 12;
    localparam int SEC_TEN_W = 3;
    localparam int SEC_ONE_LSB = 8;
    localparam int HR_TEN_LSB = 12;
    localparam int HR_TEN_W = 2;
    localparam int HR_ONE_LSB = 8;
    localparam int MIN_TEN_LSB = 4;
    localparam int MIN_TEN_W = 3;
    localparam int MIN_ONE_LSB = 0;
    localparam int DAY_TEN_LSB = 12;
    localparam int DAY_TEN_W = 2;
    localparam int DAY_ONE_LSB = 8;
    localparam int WEEKDAY_FIELD_LSB = 0;
    localparam int WEEKDAY_FIELD_W = 3;
    localparam int YR_TEN_LSB = 12;
    localparam int YR_ONE_LSB = 8;
    localparam int MTH_TEN_LSB = 4;
    localparam int MTH_ONE_LSB = 0;
    localparam int DIGIT_W = 4;
    localparam int STAT_HALF_SEC_BIT = 0;
    localparam int STAT_SYNC_BIT = 2;

    // ************************************************************
    // implemented-bit masks
    // ************************************************************
    localparam logic [DATA_W-1:0] MASK_SECONDS = 16'h7f00;
    localparam logic [DATA_W-1:0] MASK_HOURS_MINUTES = 16'h3f7f;
    localparam logic [DATA_W-1:0] MASK_DAY_WEEKDAY = 16'h3f07;
    localparam logic [DATA_W-1:0] MASK_YEAR_MONTH = 16'hff1f;

    // ************************************************************
    // reset values: 00:00:00, day 01, month 01, year 00
    // ************************************************************
    localparam logic [DATA_W-1:0] RST_SECONDS = 16'h0000;
    localparam logic [DATA_W-1:0] RST_HOURS_MINUTES = 16'h0000;
    localparam logic [DATA_W-1:0] RST_DAY_WEEKDAY = 16'h0100;
    localparam logic [DATA_W-1:0] RST_YEAR_MONTH = 16'h0001;

    // ************************************************************
    // digit limits
    // ************************************************************
    localparam logic [3:0] LIM_NINE = 4'h9;
    localparam logic [3:0] LIM_FIVE = 4'h5;
    localparam logic [3:0] LIM_TWO = 4'h2;
    localparam logic [3:0] LIM_THREE = 4'h3;
    localparam logic [3:0] LIM_SIX = 4'h6;
    localparam logic [3:0] LIM_ONE = 4'h1;
    localparam logic [3:0] HR_LAST_ONE = 4'h3;
    localparam logic [3:0] DAY_LAST_ONE = 4'h1;
    localparam logic [3:0] MTH_LAST_ONE = 4'h2;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_MHZ = 200;
    localparam int HALF_SEC_MS = 500;
    localparam int HALF_SEC_CYCLES = HALF_SEC_MS * 1000 * CLK_MHZ;
    localparam int SYNC_LEAD_CYCLES = 32;

endpackage

// ### hdl/bcd_digit.sv
/*
 * bcd_digit: one BCD digit counter with load, increment and wrap.
 * Assumes the caller supplies the wrap limit and the value to wrap to.
 */
`timescale 1ns/10ps
module bcd_digit #(
    parameter int W = 4
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [W-1:0] i_rst_val,
    input wire logic i_load,
    input wire logic [W-1:0] i_load_val,
    input wire logic i_inc,
    input wire logic [W-1:0] i_limit,
    input wire logic [W-1:0] i_wrap_val,
    output logic [W-1:0] o_val,
    output logic o_carry
);

    logic [W-1:0] val_ff;
    logic [W-1:0] nxt_val;

    assign o_val = val_ff;
    // carry when the digit sits at its limit during an increment
    assign o_carry = i_inc && (val_ff == i_limit);

    always_comb begin
        nxt_val = val_ff;
        if (i_load) begin
            nxt_val = i_load_val;
        end else if (i_inc) begin
            nxt_val = o_carry ? i_wrap_val : W'(val_ff + 1'b1);
        end
    end

    // reset value is always zero; the i_rst_val input is left unused
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            val_ff <= '0;
        end else if (i_ce) begin
            val_ff <= nxt_val;
        end
    end

endmodule

// ### hdl/half_sec_timer.sv
/*
 * half_sec_timer: divides the block clock down to half-second ticks.
 * Assumes i_clk is the timekeeping clock; i_clr restarts the half.
 */
`timescale 1ns/10ps
module half_sec_timer
    import rtc_regs_pkg::*;
#(
    parameter int HALF_CYCLES = rtc_regs_pkg::HALF_SEC_CYCLES,
    parameter int LEAD = rtc_regs_pkg::SYNC_LEAD_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_clr,
    output logic o_half,
    output logic o_sec_tick,
    output logic o_near_tick
);

    logic [31:0] cnt_ff;
    logic half_ff;
    logic wrap;

    assign wrap = (cnt_ff == 32'(HALF_CYCLES - 1));
    assign o_half = half_ff;
    assign o_sec_tick = wrap && half_ff && !i_clr;
    // window before the second rolls in which reads are unsafe
    assign o_near_tick = half_ff && (cnt_ff >= 32'(HALF_CYCLES - LEAD));

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_ff <= 32'h0000_0000;
        end else if (i_ce) begin
            if (i_clr || wrap) begin
                cnt_ff <= 32'h0000_0000;
            end else begin
                cnt_ff <= cnt_ff + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            half_ff <= 1'b0;
        end else if (i_ce) begin
            if (i_clr) begin
                half_ff <= 1'b0;
            end else if (wrap) begin
                half_ff <= !half_ff;
            end
        end
    end

endmodule

// ### testbench/rtc_time_regs_monitor.sv
/*
 * rtc_time_regs_monitor: concurrent checks on the register port of
 * rtc_time_regs. Assumes one clock domain and the async high reset.
 */
`timescale 1ns/10ps
module rtc_time_regs_monitor
    import rtc_regs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [rtc_regs_pkg::ADDR_W-1:0] i_addr,
    input wire logic [rtc_regs_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [rtc_regs_pkg::DATA_W-1:0] o_rdata,
    input wire logic o_half_second_flag,
    input wire logic o_sync_flag
);
    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_idle;
        $past(i_ce && !i_rd) |-> o_rdata == 16'h0000;
    endproperty
    a_idle: assert property (p_idle) else $error("rdata not idle");
    property p_sec;
        $past(i_ce && i_rd && i_addr == ADDR_SECONDS_VALUE) |->
            (o_rdata & ~MASK_SECONDS) == 16'h0000
            && o_rdata[14:12] <= 3'h5 && o_rdata[11:8] <= 4'h9;
    endproperty
    a_sec: assert property (p_sec) else $error("bad seconds");
    property p_hm;
        $past(i_ce && i_rd && i_addr == ADDR_HOURS_MINUTES_VALUE) |->
            (o_rdata & ~MASK_HOURS_MINUTES) == 16'h0000
            && o_rdata[13:12] <= 2'h2 && o_rdata[11:8] <= 4'h9
            && o_rdata[6:4] <= 3'h5 && o_rdata[3:0] <= 4'h9;
    endproperty
    a_hm: assert property (p_hm) else $error("bad time");
    property p_dw;
        $past(i_ce && i_rd && i_addr == ADDR_DAY_WEEKDAY_VALUE) |->
            (o_rdata & ~MASK_DAY_WEEKDAY) == 16'h0000
            && o_rdata[11:8] <= 4'h9 && o_rdata[2:0] <= 3'h6;
    endproperty
    a_dw: assert property (p_dw) else $error("bad day");
    property p_ym;
        $past(i_ce && i_rd && i_addr == ADDR_YEAR_MONTH_VALUE) |->
            (o_rdata & ~MASK_YEAR_MONTH) == 16'h0000 && o_rdata[3:0] <= 4'h9;
    endproperty
    a_ym: assert property (p_ym) else $error("bad month");
    property p_stat;
        $past(i_ce && i_rd && i_addr == ADDR_CLOCK_STATUS_LOW) |->
            o_rdata[15:3] == 13'h0000 && !o_rdata[1];
    endproperty
    a_stat: assert property (p_stat) else $error("bad status");
    property p_unmapped;
        $past(i_ce && i_rd && i_addr > ADDR_CLOCK_STATUS_LOW) |->
            o_rdata == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped");
    property p_half_clr;
        $past(i_ce && i_wr && i_addr == ADDR_SECONDS_VALUE) |->
            !o_half_second_flag;
    endproperty
    a_half_clr: assert property (p_half_clr) else $error("half set");
    // near_tick is gated by half_ff, so the sync window lies in the second half
    property p_sync_half;
        o_sync_flag |-> o_half_second_flag;
    endproperty
    a_sync_half: assert property (p_sync_half) else $error("sync");
    c_rd_sec: cover property ($past(i_rd && i_addr == ADDR_SECONDS_VALUE));
    c_wr_sec: cover property ($past(i_wr && i_addr == ADDR_SECONDS_VALUE));
    c_sync: cover property ($rose(o_sync_flag));
endmodule

bind rtc_time_regs rtc_time_regs_monitor u_mon (.i_clk(i_clk),
    .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_half_second_flag(o_half_second_flag), .o_sync_flag(o_sync_flag));

// ### testbench/tb_top.sv
/*
 * tb_top: self-checking bench for rtc_time_regs, random legal writes,
 * reset values, unmapped reads and a full calendar rollover.
 * Assumes the half period is shortened to HC cycles.
 */
`timescale 1ns/10ps
module tb_top;
    import rtc_regs_pkg::*;
    localparam int HC = 100;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_ce = 1'b1;
    logic [ADDR_W-1:0] i_addr = 3'h0;
    logic [DATA_W-1:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [DATA_W-1:0] o_rdata;
    logic o_half_second_flag;
    logic o_sync_flag;
    int mismatches = 0;
    int cmp_count = 0;
    logic [31:0] seed = 32'h168d_e0d6;
    logic [DATA_W-1:0] rdv;
    logic [DATA_W-1:0] exp_w [4];

    rtc_time_regs #(.HALF_CYCLES(HC)) u_dut (.i_clk(i_clk), .i_rst(i_rst),
        .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata),
        .o_half_second_flag(o_half_second_flag), .o_sync_flag(o_sync_flag));

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [7:0] bcd(input int n);
        return {4'(n / 10), 4'(n % 10)};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic conclude();
        $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ************************************************************
    // clock, reset, watchdog
    // ************************************************************
    initial begin
        forever #2.5 i_clk = ~i_clk;
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        mismatches++;
        conclude();
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (10) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(ADDR_SECONDS_VALUE, rdv);
        check(rdv, RST_SECONDS);
        rd(ADDR_HOURS_MINUTES_VALUE, rdv);
        check(rdv, RST_HOURS_MINUTES);
        rd(ADDR_DAY_WEEKDAY_VALUE, rdv);
        check(rdv, RST_DAY_WEEKDAY);
        rd(ADDR_YEAR_MONTH_VALUE, rdv);
        check(rdv, RST_YEAR_MONTH);
        for (int a = 5; a < 8; a++) begin
            wr(3'(a), 16'hffff);
            rd(3'(a), rdv);
            check(rdv, 16'h0000);
        end
        // seconds first: it restarts the second, so no carry lands
        for (int k = 0; k < 8; k++) begin
            exp_w[0] = {1'b0, bcd(rnd() % 60)[6:0], 8'h00};
            exp_w[1] = {2'b00, bcd(rnd() % 24)[5:0], 1'b0,
                bcd(rnd() % 60)[6:0]};
            exp_w[2] = {2'b00, bcd(1 + rnd() % 31)[5:0], 5'h00,
                3'(rnd() % 7)};
            exp_w[3] = {bcd(rnd() % 100), 3'h0, bcd(1 + rnd() % 12)[4:0]};
            wr(ADDR_SECONDS_VALUE, exp_w[0] | (rnd() & ~MASK_SECONDS));
            wr(ADDR_HOURS_MINUTES_VALUE,
                exp_w[1] | (rnd() & ~MASK_HOURS_MINUTES));
            wr(ADDR_DAY_WEEKDAY_VALUE,
                exp_w[2] | (rnd() & ~MASK_DAY_WEEKDAY));
            wr(ADDR_YEAR_MONTH_VALUE, exp_w[3] | (rnd() & ~MASK_YEAR_MONTH));
            for (int a = 0; a < 4; a++) begin
                rd(3'(a), rdv);
                check(rdv, exp_w[a]);
            end
        end
        // last second of the year: every digit but the year tens rolls over
        wr(ADDR_YEAR_MONTH_VALUE, 16'h1912);
        wr(ADDR_DAY_WEEKDAY_VALUE, 16'h3106);
        wr(ADDR_HOURS_MINUTES_VALUE, 16'h2359);
        wr(ADDR_SECONDS_VALUE, 16'h5900);
        #1 check({15'h0000, o_half_second_flag}, 16'h0000);
        repeat (HC + 5) @(posedge i_clk);
        #1 check({15'h0000, o_half_second_flag}, 16'h0001);
        repeat (HC - 20) @(posedge i_clk);
        check({15'h0000, o_sync_flag}, 16'h0001);
        rd(ADDR_CLOCK_STATUS_LOW, rdv);
        check(rdv, 16'h0005);
        repeat (30) @(posedge i_clk);
        rd(ADDR_SECONDS_VALUE, rdv);
        check(rdv, 16'h0000);
        rd(ADDR_HOURS_MINUTES_VALUE, rdv);
        check(rdv, 16'h0000);
        rd(ADDR_DAY_WEEKDAY_VALUE, rdv);
        check(rdv, 16'h0100);
        rd(ADDR_YEAR_MONTH_VALUE, rdv);
        check(rdv, 16'h2001);
        conclude();
    end
endmodule
